// ===== dv/media_model.sv
// Media stand-in that accepts zero-fill block writes from the erase walk
`timescale 1ns/100ps
module media_model (
  input  wire logic                       clock,
  input  wire logic                       reset,
  input  wire logic                       slow,
  input  wire secure_cmd_pkg::erase_req_s erase_req,
  output logic                            erase_ack,
  output int                              blocks
);
  import secure_cmd_pkg::*;
  logic phase_q;

  // Slow mode accepts every other cycle, so the request must hold meanwhile
  // Only writes exist on this side, nothing is ever read back
  assign erase_ack = erase_req.valid && (!slow || phase_q);

  // Count accepted zero writes so the bench can check the erase span
  always_ff @(posedge clock) begin
    if (reset) begin
      phase_q <= 1'b0;
      blocks  <= 0;
    end else begin
      phase_q <= !phase_q;
      if (erase_ack) blocks <= blocks + 1;
    end
  end
endmodule : media_model

// ===== dv/security_erase_freeze_cmd_assertions.sv
// Port-level checks for the secure erase and freeze command block
`timescale 1ns/100ps
`include "secure_cmd_regs.svh"
module security_erase_freeze_cmd_assertions (
  input wire logic                       clock,
  input wire logic                       reset,
  input wire logic                       ce,
  input wire secure_cmd_pkg::cmd_req_s   cmd_in,
  input wire secure_cmd_pkg::lba_t       native_max_lba,
  input wire logic                       erase_ack,
  input wire secure_cmd_pkg::erase_req_s erase_req,
  input wire logic [7:0]                 command_status_flags,
  input wire logic [7:0]                 command_error_flags,
  input wire logic                       data_ready,
  input wire logic                       cmd_done,
  input wire logic                       lock_off,
  input wire logic                       frozen
);
  import secure_cmd_pkg::*;
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  // Command side
  freeze_now_a: assert property (ce && cmd_in.write && cmd_in.opcode == `OP_FREEZE
    && !command_status_flags[7] && !data_ready |=> frozen && cmd_done)
    else $error("freeze not taken at once");
  frozen_stays_a: assert property (frozen |=> frozen)
    else $error("frozen state lost");
  frozen_abort_a: assert property (ce && frozen && cmd_in.write
    && cmd_in.opcode == `OP_SECURE_ERASE |=> cmd_done && command_status_flags == 8'h51
    && command_error_flags == 8'h04) else $error("erase not rejected while frozen");
  done_flags_a: assert property (cmd_done |-> !command_status_flags[7]
    && command_status_flags[0] == command_error_flags[2]) else $error("end flags wrong");
  lock_off_ok_a: assert property (lock_off |-> cmd_done && command_status_flags == 8'h50
    && command_error_flags == 8'h00) else $error("lock off without success");
  xfer_status_a: assert property (data_ready |-> command_status_flags == 8'h58
    && !erase_req.valid) else $error("data phase status wrong");

  // Erase walk: starts at block zero, climbs by one, ends at native maximum
  erase_first_a: assert property ($rose(erase_req.valid) |-> erase_req.lba == '0)
    else $error("erase did not start at block zero");
  erase_step_a: assert property (ce && erase_req.valid && erase_ack
    && erase_req.lba != native_max_lba |=> erase_req.valid
    && erase_req.lba == $past(erase_req.lba) + 1) else $error("erase step wrong");
  erase_hold_a: assert property (erase_req.valid && !erase_ack
    |=> erase_req.valid && $stable(erase_req.lba)) else $error("request dropped early");
  erase_end_a: assert property (ce && erase_req.valid && erase_ack
    && erase_req.lba == native_max_lba |=> !erase_req.valid ##1 (cmd_done && lock_off))
    else $error("erase end wrong");
endmodule : security_erase_freeze_cmd_assertions

bind security_erase_freeze_cmd security_erase_freeze_cmd_assertions u_chk (
  .clock(clock), .reset(reset), .ce(ce), .cmd_in(cmd_in),
  .native_max_lba(native_max_lba), .erase_ack(erase_ack), .erase_req(erase_req),
  .command_status_flags(command_status_flags), .command_error_flags(command_error_flags),
  .data_ready(data_ready), .cmd_done(cmd_done), .lock_off(lock_off), .frozen(frozen)
);

// ===== dv/tb_security_erase_freeze_cmd.sv
// Self-checking bench for the secure erase and freeze command block
`timescale 1ns/100ps
`include "secure_cmd_regs.svh"
module tb_security_erase_freeze_cmd;
  import secure_cmd_pkg::*;
  localparam logic [15:0] TIME_WORD = 16'h00A5; // Arbitrary
  localparam lba_t        MAX_LBA   = 48'h000000000005;
  logic        clock, reset, ce, security_enabled, erase_ack, slow;
  logic        data_ready, cmd_done, lock_off, frozen;
  logic [7:0]  command_status_flags, command_error_flags;
  logic [15:0] identify_word89;
  cmd_req_s    cmd_in;
  data_req_s   data_in;
  erase_req_s  erase_req;
  password_t   user_password, master_password;
  int          blocks, fails, check_count;

  security_erase_freeze_cmd #(.ERASE_TIME_WORD(TIME_WORD)) dut (
    .clock(clock), .reset(reset), .ce(ce), .cmd_in(cmd_in), .data_in(data_in),
    .security_enabled(security_enabled), .user_password(user_password),
    .master_password(master_password), .native_max_lba(MAX_LBA), .erase_ack(erase_ack),
    .erase_req(erase_req), .command_status_flags(command_status_flags),
    .command_error_flags(command_error_flags), .data_ready(data_ready),
    .cmd_done(cmd_done), .lock_off(lock_off), .frozen(frozen),
    .identify_word89(identify_word89));
  media_model media (.clock(clock), .reset(reset), .slow(slow), .erase_req(erase_req),
    .erase_ack(erase_ack), .blocks(blocks));

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic cmd(input logic [7:0] op);
    @(negedge clock);
    cmd_in = '{write: 1'b1, opcode: op};
    @(negedge clock);
    cmd_in.write = 1'b0;
  endtask : cmd

  // Bounded wait for the end pulse, then judge the flags in that very cycle
  task automatic finish_cmd(input logic [7:0] st, input logic [7:0] er, input logic lk);
    int n;
    n = 0;
    while (cmd_done !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    check("cmd_done", {15'h0, cmd_done}, 16'h0001);
    check("status", {8'h0, command_status_flags}, {8'h0, st});
    check("error", {8'h0, command_error_flags}, {8'h0, er});
    check("lock_off", {15'h0, lock_off}, {15'h0, lk});
  endtask : finish_cmd

  // One whole sector, back to back, with a clock-enable pause in the middle
  task automatic send_sector(input logic [15:0] w0, input password_t p);
    int n;
    n = 0;
    while (data_ready !== 1'b1 && n < 20) begin
      @(negedge clock);
      n++;
    end
    for (int i = 0; i < 256; i++) begin
      if (i == 100) begin
        data_in.write = 1'b0;
        ce = 1'b0;
        repeat (2) @(negedge clock);
        ce = 1'b1;
      end
      data_in.word = (i == 0) ? w0 : (i <= 16) ? p[16*(i-1)+:16] : 16'h0000;
      data_in.write = 1'b1;
      @(negedge clock);
    end
    data_in.write = 1'b0;
  endtask : send_sector

  task automatic erase_try(input logic sec, input logic prep, input logic [15:0] w0,
                           input password_t p, input logic ok);
    int b;
    security_enabled = sec;
    if (prep) begin
      cmd(`OP_ERASE_PREPARE);
      finish_cmd(8'h50, 8'h00, 1'b0);
    end
    b = blocks;
    cmd(`OP_SECURE_ERASE);
    send_sector(w0, p);
    finish_cmd(ok ? 8'h50 : 8'h51, ok ? 8'h00 : 8'h04, ok);
    check("blocks", 16'(blocks - b), ok ? 16'(MAX_LBA + 1) : 16'h0000);
  endtask : erase_try

  task automatic apply_reset();
    reset = 1'b1;
    repeat (4) @(negedge clock);
    reset = 1'b0;
    @(negedge clock);
  endtask : apply_reset

  task automatic t_reset();
    check("status", {8'h0, command_status_flags}, 16'h0050);
    check("error", {8'h0, command_error_flags}, 16'h0000);
    check("frozen", {15'h0, frozen}, 16'h0000);
    check("word89", identify_word89, TIME_WORD);
  endtask : t_reset

  task automatic t_no_prepare();
    erase_try(1'b1, 1'b0, 16'h0000, user_password, 1'b0);
  endtask : t_no_prepare

  task automatic t_mismatch();
    erase_try(1'b1, 1'b1, 16'h0000, user_password ^ 256'h1, 1'b0);
    erase_try(1'b1, 1'b1, 16'h0001, user_password, 1'b0);
  endtask : t_mismatch

  task automatic t_security_off();
    erase_try(1'b0, 1'b1, 16'h0000, user_password, 1'b0);
    erase_try(1'b0, 1'b1, 16'h0003, ~master_password, 1'b1);
  endtask : t_security_off

  task automatic t_passwords();
    erase_try(1'b1, 1'b1, 16'h0000, user_password, 1'b1);
    slow = 1'b1;
    erase_try(1'b1, 1'b1, 16'h0001, master_password, 1'b1);
    slow = 1'b0;
  endtask : t_passwords

  task automatic t_arm_lost();
    cmd(`OP_ERASE_PREPARE);
    finish_cmd(8'h50, 8'h00, 1'b0);
    cmd(`OP_SET_PASSWORD);
    erase_try(1'b1, 1'b0, 16'h0000, user_password, 1'b0);
  endtask : t_arm_lost

  task automatic t_freeze();
    logic [7:0] ops [4];
    ops = '{`OP_SET_PASSWORD, `OP_UNLOCK, `OP_SECURE_ERASE, `OP_DISABLE_PASSWORD};
    cmd(`OP_FREEZE);
    finish_cmd(8'h50, 8'h00, 1'b0);
    check("frozen", {15'h0, frozen}, 16'h0001);
    foreach (ops[i]) begin
      cmd(ops[i]);
      finish_cmd(8'h51, 8'h04, 1'b0);
      check("data_ready", {15'h0, data_ready}, 16'h0000);
    end
    cmd(`OP_ERASE_PREPARE);
    finish_cmd(8'h50, 8'h00, 1'b0);
    cmd(`OP_SECURE_ERASE);
    finish_cmd(8'h51, 8'h04, 1'b0);
    check("frozen", {15'h0, frozen}, 16'h0001);
    apply_reset();
    check("frozen", {15'h0, frozen}, 16'h0000);
  endtask : t_freeze

  // Free-running 100 MHz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Cut a hang short well past the expected run length
  initial begin
    #200000;
    fails++;
    end_of_test();
  end

  // Main sequence
  initial begin
    reset = 1'b1;
    ce = 1'b1;
    slow = 1'b0;
    security_enabled = 1'b1;
    cmd_in = '0;
    data_in = '0;
    for (int k = 0; k < 16; k++) begin
      user_password[16*k+:16] = 16'hA000 + 16'(k);
      master_password[16*k+:16] = 16'h5000 + 16'(k);
    end
    apply_reset();
    t_reset();
    t_no_prepare();
    t_mismatch();
    t_security_off();
    t_passwords();
    t_arm_lost();
    t_freeze();
    end_of_test();
  end
endmodule : tb_security_erase_freeze_cmd

// ===== rtl/param_sector_collector.sv
// Takes in one parameter sector and compares its password field
`timescale 1ns/100ps
module param_sector_collector (
  input  wire logic                     clock,
  input  wire logic                     reset,
  input  wire logic                     ce,
  input  wire logic                     start,
  input  wire secure_cmd_pkg::data_req_s data_in,
  input  wire secure_cmd_pkg::password_t user_password,
  input  wire secure_cmd_pkg::password_t master_password,
  output logic                          active,
  output logic                          done,
  output logic                          ident_master,
  output logic                          enhanced,
  output logic                          match
);
  import secure_cmd_pkg::*;

  collect_state_s s_q;
  collect_state_s s_d;

  // Pick one 16-bit word of a stored password, word 1 first
  function automatic logic [15:0] pw_word(input password_t pw, input logic [8:0] idx);
    logic [3:0] k;
    k = 4'(idx - `PW_FIRST_WORD);
    pw_word = pw[{k, 4'h0} +: 16];
  endfunction : pw_word

  // Word 0 selects the target before any password word arrives, so compare on the fly
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.count  = 9'h000;
      s_d.active = 1'b1;
      s_d.match  = 1'b1;
    end else if (s_q.active && data_in.write) begin
      if (s_q.count == 9'h000) begin
        s_d.ident    = data_in.word[`IDENT_BIT];
        s_d.enhanced = data_in.word[`ENHANCED_BIT];
      end else if (s_q.count <= `PW_LAST_WORD) begin
        if (data_in.word != (s_q.ident ? pw_word(master_password, s_q.count)
                                       : pw_word(user_password, s_q.count))) begin
          s_d.match = 1'b0;
        end
      end
      s_d.count = s_q.count + 9'h001;
      if (s_q.count == `LAST_WORD) begin
        s_d.active = 1'b0;
        s_d.done   = 1'b1;
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign active       = s_q.active;
  assign done         = s_q.done;
  assign ident_master = s_q.ident;
  assign enhanced     = s_q.enhanced;
  assign match        = s_q.match;
endmodule : param_sector_collector

// ===== rtl/secure_cmd_pkg.sv
// Types shared by the secure erase and freeze command block
package secure_cmd_pkg;
  `include "secure_cmd_regs.svh"

  typedef logic [`LBA_WIDTH-1:0] lba_t;
  typedef logic [255:0]          password_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_XFER   = 3'b001,
    ST_CHECK  = 3'b010,
    ST_ERASE  = 3'b011
  } cmd_state_e;

  typedef struct packed {
    logic       write;
    logic [7:0] opcode;
  } cmd_req_s;

  typedef struct packed {
    logic        write;
    logic [15:0] word;
  } data_req_s;

  typedef struct packed {
    logic valid;
    lba_t lba;
  } erase_req_s;

  typedef struct packed {
    cmd_state_e  st;
    logic        armed;
    logic        frozen;
    logic [7:0]  status;
    logic [7:0]  error;
    logic        done;
    logic        lock_off;
    logic [15:0] word89;
    logic        start_collect;
    logic        start_erase;
  } top_state_s;

  typedef struct packed {
    logic [8:0] count;
    logic       active;
    logic       ident;
    logic       enhanced;
    logic       match;
    logic       done;
  } collect_state_s;

  typedef struct packed {
    logic valid;
    lba_t lba;
    logic done;
  } erase_state_s;
endpackage : secure_cmd_pkg

// ===== rtl/secure_cmd_regs.svh
// Constants for the secure erase and freeze command block
`ifndef SECURE_CMD_REGS_SVH
`define SECURE_CMD_REGS_SVH

// Command opcodes
`define OP_SET_PASSWORD     8'hF1
`define OP_UNLOCK           8'hF2
`define OP_ERASE_PREPARE    8'hF3
`define OP_SECURE_ERASE     8'hF4
`define OP_FREEZE           8'hF5
`define OP_DISABLE_PASSWORD 8'hF6

// Status flag bit positions
`define STS_BUSY_BIT   7
`define STS_READY_BIT  6
`define STS_FAULT_BIT  5
`define STS_SEEK_BIT   4
`define STS_DREQ_BIT   3
`define STS_ERROR_BIT  0

// Error flag bit positions
`define ERR_ABORT_BIT  2

// Reset values
`define STATUS_RESET   8'h50
`define ERROR_RESET    8'h00

// Parameter sector layout
`define SECTOR_WORDS    9'h100
`define LAST_WORD       9'h0FF
`define PW_FIRST_WORD   9'h001
`define PW_LAST_WORD    9'h010
`define IDENT_BIT       0
`define ENHANCED_BIT    1

// Address width of the media
`define LBA_WIDTH       48

`endif

// ===== rtl/security_erase_freeze_cmd.sv
// Secure erase, erase prepare and freeze command handling
// Overview
// The host writes one opcode at a time.
// Only three opcodes do real work here.
// Prepare arms, erase consumes the arm.
// Freeze sets a sticky flag at once.
// Other security opcodes only disarm.
// While frozen those opcodes are refused.
// Unknown opcodes also break the arm.
//
// Command acceptance
// A write is taken only while idle.
// Writes during a running command drop.
// The host must wait for the end pulse.
// Back to back commands are allowed.
// Nothing is queued, so nothing is lost
// silently except a misbehaving host.
//
// Status byte
// Ready and seek-complete always stand.
// Busy stands while we decide or erase.
// Data request stands in the data phase.
// Error bit mirrors the abort bit.
// Fault, index and corrected stay zero.
// Status and error hold until the next
// command that this block answers.
//
// Error byte
// Only the abort bit is ever driven.
// It is cleared on every success.
//
// Erase flow
// Opcode taken: busy, collector started.
// Next cycle: data request raised.
// The host then sends all 256 words.
// Word 0 picks target and erase mode.
// Words 1 to 16 carry the password.
// The rest of the sector is ignored.
// Compare runs as the words arrive,
// so no copy of the sector is kept.
// After the last word: one busy cycle.
// Then the checks, in a fixed order.
//
// Check order
// First: was prepare the last command.
// Second: lock off with user target.
// Third: lock on with a wrong password.
// Any of these ends with an abort.
// Otherwise the zero-fill walk starts.
// With the lock off the compare result
// is simply not looked at.
//
// Zero-fill walk
// One block write per media handshake.
// Blocks go from zero to native maximum.
// The host-visible maximum is not an
// input here, so it cannot shorten it.
// Nothing is read back after writing.
// Defect tables have no path from here.
// A slow media side only stretches time.
//
// End of erase
// Walk done: lock-off pulse, end pulse.
// Status returns to plain ready.
// The lock function is owned outside;
// it must act on the lock-off pulse.
// The master password is never touched,
// since it is only an input here.
//
// Prepare arm
// Set by prepare, cleared by anything.
// Erase consumes it whatever the result.
// Freeze also clears it.
// A refused command clears it as well.
// So a stale arm can never leak into a
// later erase after other traffic.
//
// Freeze
// Answered in the very next cycle.
// No data phase is ever opened.
// Only reset clears the frozen flag;
// reset stands for a power cycle here.
// Prepare is still answered when frozen,
// but the erase that follows is refused
// before any sector is taken.
//
// Clock enable
// Low freezes every flop in all parts.
// The host must not send words then,
// as a held word would be lost.
// Pulses stretch while it is low.
//
// Identify word
// The erase time word is a parameter.
// It reads zero until the first
// enabled clock after reset.
//
// Limitations
// Enhanced erase is never performed;
// a request for it gets a normal erase.
// No progress indication is given.
// A sector shorter than 256 words
// leaves the block waiting for data;
// the host must then reset it.
// The erase cannot be cut short.
//
// Trade-offs
// Compare on the fly saves a buffer
// at the cost of ordering words 0 first.
// Registered outputs add one cycle of
// latency to every status change.
//
`timescale 1ns/100ps
module security_erase_freeze_cmd #(
  parameter logic [15:0] ERASE_TIME_WORD = 16'h0000
) (
  input  wire logic                      clock,
  input  wire logic                      reset,
  input  wire logic                      ce,
  input  wire secure_cmd_pkg::cmd_req_s   cmd_in,
  input  wire secure_cmd_pkg::data_req_s  data_in,
  input  wire logic                      security_enabled,
  input  wire secure_cmd_pkg::password_t  user_password,
  input  wire secure_cmd_pkg::password_t  master_password,
  input  wire secure_cmd_pkg::lba_t       native_max_lba,
  input  wire logic                      erase_ack,
  output secure_cmd_pkg::erase_req_s      erase_req,
  output logic [7:0]                     command_status_flags,
  output logic [7:0]                     command_error_flags,
  output logic                           data_ready,
  output logic                           cmd_done,
  output logic                           lock_off,
  output logic                           frozen,
  output logic [15:0]                    identify_word89
);
  import secure_cmd_pkg::*;

  top_state_s s_q;
  top_state_s s_d;

  logic collect_active;
  logic collect_done;
  logic ident_master;
  logic enhanced_req;
  logic pw_match;
  logic erase_done;

  // Build a status byte; ready and seek-complete always stand while idle or working
  function automatic logic [7:0] status_byte(input logic busy, input logic dreq,
                                             input logic err);
    logic [7:0] b;
    b = 8'h00;
    b[`STS_BUSY_BIT]  = busy;
    b[`STS_READY_BIT] = 1'b1;
    b[`STS_SEEK_BIT]  = 1'b1;
    b[`STS_DREQ_BIT]  = dreq;
    b[`STS_ERROR_BIT] = err;
    status_byte = b;
  endfunction : status_byte

  // Build the error byte; only the abort bit is ever reported here
  function automatic logic [7:0] error_byte(input logic abort);
    logic [7:0] b;
    b = 8'h00;
    b[`ERR_ABORT_BIT] = abort;
    error_byte = b;
  endfunction : error_byte

  // Parameter sector intake and password comparison
  param_sector_collector u_collect (
    .clock           (clock),
    .reset           (reset),
    .ce              (ce),
    .start           (s_q.start_collect),
    .data_in         (data_in),
    .user_password   (user_password),
    .master_password (master_password),
    .active          (collect_active),
    .done            (collect_done),
    .ident_master    (ident_master),
    .enhanced        (enhanced_req),
    .match           (pw_match)
  );

  // Media zero-fill walker
  zero_erase_sequencer u_erase (
    .clock          (clock),
    .reset          (reset),
    .ce             (ce),
    .start          (s_q.start_erase),
    .native_max_lba (native_max_lba),
    .erase_ack      (erase_ack),
    .erase_req      (erase_req),
    .done           (erase_done)
  );

  // Command sequencing; commands written while a command runs are ignored
  always_comb begin
    s_d = s_q;
    s_d.done          = 1'b0;
    s_d.lock_off      = 1'b0;
    s_d.start_collect = 1'b0;
    s_d.start_erase   = 1'b0;
    s_d.word89        = ERASE_TIME_WORD;
    case (s_q.st)
      ST_IDLE: begin
        if (cmd_in.write) begin
          case (cmd_in.opcode)
            `OP_ERASE_PREPARE: begin
              // No data phase: arm and complete at once
              s_d.armed  = 1'b1;
              s_d.status = status_byte(1'b0, 1'b0, 1'b0);
              s_d.error  = error_byte(1'b0);
              s_d.done   = 1'b1;
            end
            `OP_FREEZE: begin
              // Nothing ever clears this flag except reset at power-up
              s_d.frozen = 1'b1;
              s_d.armed  = 1'b0;
              s_d.status = status_byte(1'b0, 1'b0, 1'b0);
              s_d.error  = error_byte(1'b0);
              s_d.done   = 1'b1;
            end
            `OP_SECURE_ERASE: begin
              if (s_q.frozen) begin
                s_d.armed  = 1'b0;
                s_d.status = status_byte(1'b0, 1'b0, 1'b1);
                s_d.error  = error_byte(1'b1);
                s_d.done   = 1'b1;
              end else begin
                // Sector comes in first; checks only after it has all arrived
                s_d.st            = ST_XFER;
                s_d.start_collect = 1'b1;
                s_d.status        = status_byte(1'b1, 1'b0, 1'b0);
                s_d.error         = error_byte(1'b0);
              end
            end
            `OP_SET_PASSWORD, `OP_UNLOCK, `OP_DISABLE_PASSWORD: begin
              s_d.armed = 1'b0;
              if (s_q.frozen) begin
                s_d.status = status_byte(1'b0, 1'b0, 1'b1);
                s_d.error  = error_byte(1'b1);
                s_d.done   = 1'b1;
              end
            end
            default: begin
              // Any other command breaks the prepare-then-erase pairing
              s_d.armed = 1'b0;
            end
          endcase
        end
      end
      ST_XFER: begin
        // Data request stands while the collector still wants words; the start
        // pulse counts too, so no idle-looking status slips out before it
        s_d.status = status_byte(1'b0, collect_active || s_q.start_collect, 1'b0);
        if (collect_done) begin
          s_d.st     = ST_CHECK;
          s_d.status = status_byte(1'b1, 1'b0, 1'b0);
        end
      end
      ST_CHECK: begin
        // Arming is single use whatever the outcome
        s_d.armed = 1'b0;
        if (!s_q.armed) begin
          s_d.st     = ST_IDLE;
          s_d.status = status_byte(1'b0, 1'b0, 1'b1);
          s_d.error  = error_byte(1'b1);
          s_d.done   = 1'b1;
        end else if (!security_enabled && !ident_master) begin
          s_d.st     = ST_IDLE;
          s_d.status = status_byte(1'b0, 1'b0, 1'b1);
          s_d.error  = error_byte(1'b1);
          s_d.done   = 1'b1;
        end else if (security_enabled && !pw_match) begin
          s_d.st     = ST_IDLE;
          s_d.status = status_byte(1'b0, 1'b0, 1'b1);
          s_d.error  = error_byte(1'b1);
          s_d.done   = 1'b1;
        end else begin
          // Security off skips the compare; enhanced request still gets normal erase
          s_d.st          = ST_ERASE;
          s_d.start_erase = 1'b1;
        end
      end
      ST_ERASE: begin
        // Only user sectors are written; defect tables have no path from here
        if (erase_done) begin
          s_d.st       = ST_IDLE;
          s_d.lock_off = 1'b1;
          s_d.status   = status_byte(1'b0, 1'b0, 1'b0);
          s_d.error    = error_byte(1'b0);
          s_d.done     = 1'b1;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q        <= '0;
      s_q.st     <= ST_IDLE;
      s_q.status <= `STATUS_RESET;
      s_q.error  <= `ERROR_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // Outputs are flop bits; the master password itself lives outside this block
  assign command_status_flags = s_q.status;
  assign command_error_flags  = s_q.error;
  assign data_ready           = s_q.status[`STS_DREQ_BIT];
  assign cmd_done             = s_q.done;
  assign lock_off             = s_q.lock_off;
  assign frozen               = s_q.frozen;
  assign identify_word89      = s_q.word89;

  // Enhanced mode bit is captured but deliberately has no effect
  logic unused_enh;
  assign unused_enh = enhanced_req;
endmodule : security_erase_freeze_cmd

// ===== rtl/zero_erase_sequencer.sv
// Walks every block from zero to the native maximum writing zeros
`timescale 1ns/100ps
module zero_erase_sequencer (
  input  wire logic                  clock,
  input  wire logic                  reset,
  input  wire logic                  ce,
  input  wire logic                  start,
  input  wire secure_cmd_pkg::lba_t  native_max_lba,
  input  wire logic                  erase_ack,
  output secure_cmd_pkg::erase_req_s erase_req,
  output logic                       done
);
  import secure_cmd_pkg::*;

  erase_state_s s_q;
  erase_state_s s_d;

  // One zero-fill sector write per handshake; nothing is read back
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (start) begin
      s_d.valid = 1'b1;
      s_d.lba   = '0;
    end else if (s_q.valid && erase_ack) begin
      if (s_q.lba == native_max_lba) begin
        s_d.valid = 1'b0;
        s_d.done  = 1'b1;
      end else begin
        s_d.lba = s_q.lba + lba_t'(1);
      end
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign erase_req.valid = s_q.valid;
  assign erase_req.lba   = s_q.lba;
  assign done            = s_q.done;
endmodule : zero_erase_sequencer
